/* inc/pcstk_map.svh */
// register indices, field positions, reset values and fixed addresses of the counter and stack
`ifndef PCSTK_MAP_SVH
`define PCSTK_MAP_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define PCSTK_IDX_STKP 12'hfed
`define PCSTK_IDX_TOP_ENTRY_LOW 12'hfee
`define PCSTK_IDX_TOP_ENTRY_HIGH 12'hfef
`define PCSTK_IDX_CTRL 12'hff0
`define PCSTK_IDX_STAT 12'hff1
`define PCSTK_IDX_MASK 12'hff2
`define PCSTK_IDX_PCRD 12'hff3

// ************************************************************
// fields and reset values
// ************************************************************
`define PCSTK_SP_EMPTY 5'h1f
`define PCSTK_SP_LAST 5'h0f
`define PCSTK_PC_RESET 15'h0000
`define PCSTK_INT_VECTOR 15'h0004
`define PCSTK_CTRL_FRE 0
`define PCSTK_STAT_OVF 0
`define PCSTK_STAT_UNF 1
`define PCSTK_STAT_W 2
`define PCSTK_BRA_MSB 8
`define PCSTK_TOP_ENTRY_LOW_MASK 15'h00ff
`define PCSTK_TOP_ENTRY_HIGH_MASK 15'h7f00

`endif

/* inc/pcstk_pkg.sv */
// types shared by the program counter and return stack
package pcstk_pkg;

    // core operation presented for one instruction cycle
    typedef enum logic [3:0] {
        PCSTK_OP_IDLE = 4'h0,
        PCSTK_OP_STEP = 4'h1,
        PCSTK_OP_WRPCL = 4'h2,
        PCSTK_OP_CALL = 4'h3,
        PCSTK_OP_CALL_VIA_W = 4'h4,
        PCSTK_OP_BRW = 4'h5,
        PCSTK_OP_BRA = 4'h6,
        PCSTK_OP_INTR = 4'h7,
        PCSTK_OP_RETURN = 4'h8,
        PCSTK_OP_RETURN_WITH_LITERAL = 4'h9,
        PCSTK_OP_RETURN_FROM_INTERRUPT = 4'ha
    } pcstk_op_t;

endpackage : pcstk_pkg

/* logic/pcstk_stack_mem.sv */
// return address storage: one masked write port, one combinational read port
`timescale 1ns/1ps
`default_nettype none

module pcstk_stack_mem #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 15,
    parameter int AW = 4
) (
    input wire logic pclk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_mask,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data
);

    // entries are not reset; contents are unknown until pushed or written
    logic [WIDTH-1:0] mem_q [DEPTH];

    assign rd_data = mem_q[rd_idx];

    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem_q[wr_idx] <= (mem_q[wr_idx] & ~wr_mask) | (wr_data & wr_mask);
        end
    end

endmodule : pcstk_stack_mem

`default_nettype wire

/* logic/pcstk_top.sv */
// program counter loading and sixteen-level return stack with apb register access
`timescale 1ns/1ps
`default_nettype none

`include "pcstk_map.svh"

module pcstk_top import pcstk_pkg::*; #(
    parameter int STK_DEPTH = 16,
    parameter logic [14:0] INT_VECTOR = `PCSTK_INT_VECTOR
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q,
    input wire pcstk_op_t core_op,
    input wire logic [10:0] operand,
    input wire logic [7:0] w_value,
    input wire logic [7:0] pcl_wr_data,
    input wire logic [6:0] pc_high_latch,
    output logic [14:0] pc_q,
    output logic [4:0] stack_ptr_q,
    output logic fault_reset_q,
    output logic irq_q
);

    // ************************************************************
    // helper functions
    // ************************************************************
    function automatic logic [14:0] pcstk_add(input logic [14:0] a, input logic [14:0] b);
        logic [14:0] s;
        s = a + b;
        return s;
    endfunction : pcstk_add

    function automatic logic pcstk_hit(input logic [15:0] addr, input logic [11:0] idx);
        return (addr[15:14] == 2'h0) && (addr[1:0] == 2'h0) && (addr[13:2] == idx);
    endfunction : pcstk_hit

    // ************************************************************
    // state
    // ************************************************************
    logic [4:0] sp_q;
    logic [4:0] sp_d;
    logic fre_q;
    logic [`PCSTK_STAT_W-1:0] stat_q;
    logic [`PCSTK_STAT_W-1:0] stat_d;
    logic [`PCSTK_STAT_W-1:0] mask_q;
    logic [14:0] pc_d;

    // ************************************************************
    // operation decode
    // ************************************************************
    wire logic op_push;
    wire logic op_pop;
    wire logic ovf_evt;
    wire logic unf_evt;
    wire logic fault;

    assign op_push = (core_op == PCSTK_OP_CALL) || (core_op == PCSTK_OP_CALL_VIA_W) || (core_op == PCSTK_OP_INTR);
    assign op_pop = (core_op == PCSTK_OP_RETURN) || (core_op == PCSTK_OP_RETURN_WITH_LITERAL) || (core_op == PCSTK_OP_RETURN_FROM_INTERRUPT);
    assign ovf_evt = op_push && (sp_q == `PCSTK_SP_LAST);
    assign unf_evt = op_pop && (sp_q == `PCSTK_SP_EMPTY);
    assign fault = (ovf_evt || unf_evt) && fre_q;

    // ************************************************************
    // apb decode
    // ************************************************************
    wire logic apb_setup;
    wire logic apb_acc;
    wire logic apb_wr;
    wire logic hit_stkp;
    wire logic hit_top_entry_low;
    wire logic hit_top_entry_high;
    wire logic hit_ctrl;
    wire logic hit_stat;
    wire logic hit_mask;
    wire logic hit_pcrd;
    wire logic mapped;

    assign apb_setup = psel && !penable;
    assign apb_acc = psel && penable && pready_q;
    assign apb_wr = apb_acc && pwrite && !pslverr_q;
    assign hit_stkp = pcstk_hit(paddr, `PCSTK_IDX_STKP);
    assign hit_top_entry_low = pcstk_hit(paddr, `PCSTK_IDX_TOP_ENTRY_LOW);
    assign hit_top_entry_high = pcstk_hit(paddr, `PCSTK_IDX_TOP_ENTRY_HIGH);
    assign hit_ctrl = pcstk_hit(paddr, `PCSTK_IDX_CTRL);
    assign hit_stat = pcstk_hit(paddr, `PCSTK_IDX_STAT);
    assign hit_mask = pcstk_hit(paddr, `PCSTK_IDX_MASK);
    assign hit_pcrd = pcstk_hit(paddr, `PCSTK_IDX_PCRD);
    assign mapped = hit_stkp || hit_top_entry_low || hit_top_entry_high || hit_ctrl || hit_stat || hit_mask || hit_pcrd;

    // ************************************************************
    // return stack storage
    // ************************************************************
    wire logic [4:0] sp_inc;
    wire logic [4:0] sp_dec;
    wire logic [14:0] tos;
    wire logic [14:0] pc_inc;
    wire logic push_wr;
    wire logic tos_wr;
    wire logic mem_wr;
    wire logic [3:0] mem_idx;
    wire logic [14:0] mem_mask;
    wire logic [14:0] mem_data;

    // five-bit arithmetic wraps 0x1f to 0x00
    assign sp_inc = sp_q + 5'h01;
    assign sp_dec = sp_q - 5'h01;
    assign pc_inc = pcstk_add(pc_q, 15'h0001);
    // push writes at the incremented slot
    assign push_wr = op_push && !fault;
    // core push owns the port; a colliding top-pair write is dropped
    assign tos_wr = apb_wr && (hit_top_entry_low || hit_top_entry_high) && !op_push;
    assign mem_wr = push_wr || tos_wr;
    // low four bits index, so pushes past sixteen wrap
    assign mem_idx = push_wr ? sp_inc[3:0] : sp_q[3:0];
    assign mem_mask = push_wr ? 15'h7fff : (hit_top_entry_low ? `PCSTK_TOP_ENTRY_LOW_MASK : `PCSTK_TOP_ENTRY_HIGH_MASK);
    // top pair writes land in the selected entry
    assign mem_data = push_wr ? pc_inc : {pwdata[6:0], pwdata[7:0]};

    pcstk_stack_mem #(
        .DEPTH(STK_DEPTH),
        .WIDTH(15),
        .AW(4)
    ) u_mem (
        .pclk(pclk),
        .wr_en(mem_wr),
        .wr_idx(mem_idx),
        .wr_mask(mem_mask),
        .wr_data(mem_data),
        .rd_idx(sp_q[3:0]),
        .rd_data(tos)
    );

    // ************************************************************
    // program counter targets
    // ************************************************************
    wire logic [14:0] wrpcl_target;
    wire logic [14:0] call_target;
    wire logic [14:0] call_via_w_target;
    wire logic [14:0] brw_target;
    wire logic [14:0] bra_target;
    wire logic [14:0] bra_off;

    // latch only read, never written here
    assign wrpcl_target = {pc_high_latch, pcl_wr_data};
    // upper four from latch, rest from operand
    assign call_target = {pc_high_latch[6:3], operand};
    // latch and w form the target
    assign call_via_w_target = {pc_high_latch, w_value};
    assign brw_target = pcstk_add(pc_inc, {7'h00, w_value});
    // signed operand may cross block edges
    assign bra_off = {{(14 - `PCSTK_BRA_MSB){operand[`PCSTK_BRA_MSB]}}, operand[`PCSTK_BRA_MSB:0]};
    assign bra_target = pcstk_add(pc_inc, bra_off);

    assign pc_d = fault ? `PCSTK_PC_RESET :
                  (core_op == PCSTK_OP_STEP) ? pc_inc :
                  (core_op == PCSTK_OP_WRPCL) ? wrpcl_target :
                  (core_op == PCSTK_OP_CALL) ? call_target :
                  (core_op == PCSTK_OP_CALL_VIA_W) ? call_via_w_target :
                  (core_op == PCSTK_OP_BRW) ? brw_target :
                  (core_op == PCSTK_OP_BRA) ? bra_target :
                  (core_op == PCSTK_OP_INTR) ? INT_VECTOR :
                  op_pop ? tos :
                  pc_q;

    // empty state after a fault reset
    // pop reads entry before the decrement
    // pointer writes lose to a core push or pop in the same cycle
    assign sp_d = fault ? `PCSTK_SP_EMPTY :
                  op_push ? sp_inc :
                  op_pop ? sp_dec :
                  (apb_wr && hit_stkp) ? pwdata[4:0] :
                  sp_q;

    // ************************************************************
    // status and interrupt
    // ************************************************************
    wire logic [`PCSTK_STAT_W-1:0] stat_evt;
    wire logic [`PCSTK_STAT_W-1:0] stat_clr;
    wire logic [`PCSTK_STAT_W-1:0] mask_d;

    // flags set whether or not reset is enabled
    assign stat_evt = {unf_evt, ovf_evt};
    assign stat_clr = (apb_wr && hit_stat) ? pwdata[`PCSTK_STAT_W-1:0] : '0;
    // set wins over a write-one clear in the same cycle
    assign stat_d = (stat_q & ~stat_clr) | stat_evt;
    // new mask feeds irq so the output never lags a mask write
    assign mask_d = (apb_wr && hit_mask) ? pwdata[`PCSTK_STAT_W-1:0] : mask_q;

    // ************************************************************
    // read mux
    // ************************************************************
    wire logic [31:0] rd_mux;

    // selected entry visible through top pair
    assign rd_mux = hit_stkp ? {27'h0, sp_q} :
                    hit_top_entry_low ? {24'h0, tos[7:0]} :
                    hit_top_entry_high ? {25'h0, tos[14:8]} :
                    hit_ctrl ? {31'h0, fre_q} :
                    hit_stat ? {30'h0, stat_q} :
                    hit_mask ? {30'h0, mask_q} :
                    hit_pcrd ? {17'h0, pc_q} :
                    32'h0;

    // ************************************************************
    // registers
    // ************************************************************
    // counter cleared on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= `PCSTK_PC_RESET;
            sp_q <= `PCSTK_SP_EMPTY;
            stack_ptr_q <= `PCSTK_SP_EMPTY;
            fault_reset_q <= 1'b0;
        end else begin
            pc_q <= pc_d;
            sp_q <= sp_d;
            stack_ptr_q <= sp_d;
            fault_reset_q <= fault;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fre_q <= 1'b0;
            mask_q <= '0;
            stat_q <= '0;
            irq_q <= 1'b0;
        end else begin
            if (apb_wr && hit_ctrl) begin
                fre_q <= pwdata[`PCSTK_CTRL_FRE];
            end
            mask_q <= mask_d;
            stat_q <= stat_d;
            irq_q <= |(stat_d & mask_d);
        end
    end

    // read data sampled in setup; fixed one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= apb_setup;
            pslverr_q <= apb_setup && !mapped;
            if (apb_setup) begin
                prdata_q <= pwrite ? 32'h0 : rd_mux;
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_pcl_load: assert property ((core_op == PCSTK_OP_WRPCL) && !fault |=> pc_q == $past(wrpcl_target))
        else $error("low byte write did not load the counter");
    chk_call_target: assert property ((core_op == PCSTK_OP_CALL) && !fault |=> pc_q == $past(call_target))
        else $error("call target wrong");
    chk_call_via_w_target: assert property ((core_op == PCSTK_OP_CALL_VIA_W) && !fault |=> pc_q == $past(call_via_w_target))
        else $error("computed call target wrong");
    chk_brw_target: assert property ((core_op == PCSTK_OP_BRW) |=> pc_q == $past(brw_target))
        else $error("branch by w target wrong");
    chk_bra_target: assert property ((core_op == PCSTK_OP_BRA) |=> pc_q == $past(bra_target))
        else $error("offset jump target wrong");
    chk_push_pop_pair: assert property (push_wr ##1 op_pop |=> pc_q == $past(pc_inc, 2))
        else $error("return did not restore the pushed address");
    chk_first_push: assert property (op_push && (sp_q == `PCSTK_SP_EMPTY) |=> sp_q == 5'h00)
        else $error("first push did not reach entry zero");
    chk_overflow_flag: assert property (ovf_evt |=> stat_q[`PCSTK_STAT_OVF] && stack_ptr_q == sp_q)
        else $error("overflow flag not set");
    chk_underflow_flag: assert property (unf_evt |=> stat_q[`PCSTK_STAT_UNF])
        else $error("underflow flag not set");
    chk_fault_reset: assert property (fault |=> fault_reset_q && pc_q == 15'h0 && sp_q == `PCSTK_SP_EMPTY)
        else $error("fault reset did not clear counter and pointer");
    chk_circular_wrap: assert property (ovf_evt && !fre_q |=> sp_q == 5'h10)
        else $error("wrap push did not advance the pointer");
    chk_irq_level: assert property (irq_q == |(stat_q & mask_q))
        else $error("interrupt output disagrees with status and mask");
    chk_pop_restore: assert property (op_pop && !fault |=> pc_q == $past(tos) && sp_q == $past(sp_dec))
        else $error("return did not load the selected entry");
    chk_underflow_wrap: assert property (unf_evt && !fre_q |=> sp_q == 5'h1e)
        else $error("underflow without fault reset left a wrong pointer");
    chk_flag_sticky: assert property (stat_q[`PCSTK_STAT_OVF] && !stat_clr[`PCSTK_STAT_OVF]
        |=> stat_q[`PCSTK_STAT_OVF])
        else $error("overflow flag cleared without a write");
    chk_pointer_write: assert property (apb_wr && hit_stkp && !op_push && !op_pop
        |=> sp_q == $past(pwdata[4:0]))
        else $error("pointer write not taken");
    chk_step_inc: assert property ((core_op == PCSTK_OP_STEP) |=> pc_q == $past(pc_inc))
        else $error("step did not advance the counter");
    chk_apb_answer: assert property (apb_setup |=> pready_q && (pslverr_q == !$past(mapped)))
        else $error("bus answer not given after setup");

    // ************************************************************
    // cover points
    // ************************************************************
    cov_call_return: cover property (push_wr ##[1:20] op_pop);
    cov_pair_back: cover property (push_wr ##1 op_pop);
    cov_overflow_wrap: cover property (ovf_evt && !fre_q);
    cov_underflow_reset: cover property (unf_evt && fre_q);
    cov_tos_write: cover property (tos_wr);

endmodule : pcstk_top

`default_nettype wire

/* test/pcstk_core_model.sv */
// core-side model that issues one instruction operation per cycle
`timescale 1ns/1ps
`default_nettype none

module pcstk_core_model import pcstk_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire pcstk_op_t req_op,
    input wire logic [10:0] req_opd,
    input wire logic [7:0] req_w,
    input wire logic [7:0] req_pcl,
    input wire logic [6:0] req_lat,
    output var pcstk_op_t core_op,
    output logic [10:0] operand,
    output logic [7:0] w_value,
    output logic [7:0] pcl_wr_data,
    output logic [6:0] pc_high_latch
);
    // ****************
    // instruction issue
    // ****************
    // one op per cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_op <= PCSTK_OP_IDLE;
            operand <= 11'h000;
            w_value <= 8'h00;
            pcl_wr_data <= 8'h00;
            pc_high_latch <= 7'h00;
        end else begin
            core_op <= req_op;
            operand <= req_opd;
            w_value <= req_w;
            pcl_wr_data <= req_pcl;
            pc_high_latch <= req_lat;
        end
    end
endmodule : pcstk_core_model

`default_nettype wire

/* test/program_counter_and_call_stack_tb.sv */
// self-checking bench for the counter and return stack
`timescale 1ns/1ps
`default_nettype none

`include "pcstk_map.svh"

module program_counter_and_call_stack_tb import pcstk_pkg::*; ;
    // ****************
    // signals
    // ****************
    typedef struct packed {
        pcstk_op_t op;
        logic [10:0] opd;
        logic [7:0] w, pc_low_byte_reg;
        logic [6:0] lat;
        logic [14:0] pc;
        logic [4:0] sp;
    } pcstk_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata_q, rd;
    logic pready_q, pslverr_q, fault_reset_q, irq_q, err;
    pcstk_op_t core_op;
    logic [10:0] operand;
    logic [7:0] w_value, pcl_wr_data;
    logic [6:0] pc_high_latch;
    logic [14:0] pc_q;
    logic [4:0] stack_ptr_q;
    pcstk_row_t req_r = '0;
    int miscompares = 0, checked = 0, i, n;
    pcstk_row_t rows [12] = '{
        '{PCSTK_OP_STEP, 11'h000, 8'h00, 8'h00, 7'h00, 15'h0001, 5'h1f},
        '{PCSTK_OP_WRPCL, 11'h000, 8'h00, 8'h34, 7'h12, 15'h1234, 5'h1f},
        '{PCSTK_OP_BRW, 11'h000, 8'hf0, 8'h00, 7'h12, 15'h1325, 5'h1f},
        '{PCSTK_OP_BRA, 11'h1fe, 8'h00, 8'h00, 7'h12, 15'h1324, 5'h1f},
        '{PCSTK_OP_BRA, 11'h0ff, 8'h00, 8'h00, 7'h12, 15'h1424, 5'h1f},
        '{PCSTK_OP_CALL, 11'h5a5, 8'h00, 8'h00, 7'h55, 15'h55a5, 5'h00},
        '{PCSTK_OP_CALL_VIA_W, 11'h000, 8'h77, 8'h00, 7'h3c, 15'h3c77, 5'h01},
        '{PCSTK_OP_INTR, 11'h000, 8'h00, 8'h00, 7'h3c, `PCSTK_INT_VECTOR, 5'h02},
        '{PCSTK_OP_RETURN_FROM_INTERRUPT, 11'h000, 8'h00, 8'h00, 7'h3c, 15'h3c78, 5'h01},
        '{PCSTK_OP_RETURN_WITH_LITERAL, 11'h000, 8'h00, 8'h00, 7'h3c, 15'h55a6, 5'h00},
        '{PCSTK_OP_RETURN, 11'h000, 8'h00, 8'h00, 7'h3c, 15'h1425, 5'h1f},
        '{PCSTK_OP_IDLE, 11'h000, 8'h00, 8'h00, 7'h3c, 15'h1425, 5'h1f}
    };

    pcstk_top #(.STK_DEPTH(16), .INT_VECTOR(`PCSTK_INT_VECTOR)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
        .pslverr_q(pslverr_q), .core_op(core_op), .operand(operand), .w_value(w_value),
        .pcl_wr_data(pcl_wr_data), .pc_high_latch(pc_high_latch), .pc_q(pc_q),
        .stack_ptr_q(stack_ptr_q), .fault_reset_q(fault_reset_q), .irq_q(irq_q)
    );
    pcstk_core_model core (
        .pclk(pclk), .presetn(presetn), .req_op(req_r.op), .req_opd(req_r.opd), .req_w(req_r.w),
        .req_pcl(req_r.pc_low_byte_reg), .req_lat(req_r.lat), .core_op(core_op), .operand(operand),
        .w_value(w_value), .pcl_wr_data(pcl_wr_data), .pc_high_latch(pc_high_latch)
    );

    // ****************
    // tasks
    // ****************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    function automatic pcstk_row_t mk(input pcstk_op_t o, input logic [10:0] opd);
        // latch 0 keeps call targets equal to the operand
        mk = '{o, opd, 8'h00, 8'h00, 7'h00, 15'h0000, 5'h00};
    endfunction : mk

    task automatic do_op(input pcstk_row_t r);
        @(posedge pclk);
        req_r <= r;
        @(posedge pclk);
        req_r.op <= PCSTK_OP_IDLE;
        @(posedge pclk);
        #1;
    endtask : do_op

    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // pready_q is a register, so its value holds up to the sampling edge
        for (n = 0; n < 20; n++) begin
            #1;
            if (pready_q === 1'b1) break;
            @(posedge pclk);
        end
        chk("pready", 32'h1, 32'(pready_q));
        rd = prdata_q;
        err = pslverr_q;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string nm, input logic [11:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(nm, exp, rd);
    endtask : rdchk

    task automatic finish_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    // ****************
    // tests
    // ****************
    initial begin
        forever #12.5 pclk = ~pclk;
    end

    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("pc", 32'h0, 32'(pc_q));
        rdchk("stkp", `PCSTK_IDX_STKP, 32'h1f);
        for (i = 0; i < 12; i++) begin
            do_op(rows[i]);
            chk("pc", 32'(rows[i].pc), 32'(pc_q));
            chk("sp", 32'(rows[i].sp), 32'(stack_ptr_q));
        end
        // call then return on back-to-back cycles
        @(posedge pclk);
        req_r <= mk(PCSTK_OP_CALL, 11'h2aa);
        @(posedge pclk);
        req_r.op <= PCSTK_OP_RETURN;
        @(posedge pclk);
        req_r.op <= PCSTK_OP_IDLE;
        repeat (2) @(posedge pclk);
        #1;
        chk("pc", 32'h1426, 32'(pc_q));
        chk("sp", 32'h1f, 32'(stack_ptr_q));
        apb(1'b1, `PCSTK_IDX_STKP, 32'h3);
        apb(1'b1, `PCSTK_IDX_TOP_ENTRY_LOW, 32'hab);
        apb(1'b1, `PCSTK_IDX_TOP_ENTRY_HIGH, 32'h5c);
        rdchk("top_entry_high", `PCSTK_IDX_TOP_ENTRY_HIGH, 32'h5c);
        rdchk("top_entry_low", `PCSTK_IDX_TOP_ENTRY_LOW, 32'hab);
        do_op(mk(PCSTK_OP_RETURN, 11'h000));
        chk("pc", 32'h5cab, 32'(pc_q));
        chk("sp", 32'h2, 32'(stack_ptr_q));
        apb(1'b0, 12'h000, 32'h0);
        chk("slverr", 32'h1, 32'(err));
        chk("unmapped", 32'h0, rd);
        rdchk("pcrd", `PCSTK_IDX_PCRD, 32'h5cab);
        apb(1'b1, `PCSTK_IDX_STKP, 32'h1f);
        for (i = 1; i < 18; i++) do_op(mk(PCSTK_OP_CALL, 11'(i * 8)));
        chk("sp", 32'h10, 32'(stack_ptr_q));
        rdchk("stat", `PCSTK_IDX_STAT, 32'h1);
        chk("irq", 32'h0, 32'(irq_q));
        apb(1'b1, `PCSTK_IDX_MASK, 32'h3);
        apb(1'b1, `PCSTK_IDX_STKP, 32'h0);
        chk("irq", 32'h1, 32'(irq_q));
        rdchk("top_entry_low", `PCSTK_IDX_TOP_ENTRY_LOW, 32'h81);
        apb(1'b1, `PCSTK_IDX_STAT, 32'h1);
        apb(1'b1, `PCSTK_IDX_STKP, 32'h1f);
        chk("irq", 32'h0, 32'(irq_q));
        do_op(mk(PCSTK_OP_RETURN, 11'h000));
        chk("pc", 32'h79, 32'(pc_q));
        chk("sp", 32'h1e, 32'(stack_ptr_q));
        rdchk("stat", `PCSTK_IDX_STAT, 32'h2);
        apb(1'b1, `PCSTK_IDX_STAT, 32'h3);
        apb(1'b1, `PCSTK_IDX_CTRL, 32'h1);
        // overflow first, then underflow, both with fault reset on
        for (i = 0; i < 2; i++) begin
            apb(1'b1, `PCSTK_IDX_STKP, i ? 32'h1f : 32'h0f);
            do_op(mk(i ? PCSTK_OP_RETURN : PCSTK_OP_CALL, 11'h123));
            n = 0;
            repeat (3) begin
                if (fault_reset_q === 1'b1) n++;
                @(posedge pclk);
                #1;
            end
            chk("pulses", 32'h1, 32'(n));
            chk("pc", 32'h0, 32'(pc_q));
            chk("sp", 32'h1f, 32'(stack_ptr_q));
        end
        rdchk("stat", `PCSTK_IDX_STAT, 32'h3);
        // second reset in mid-run
        do_op(mk(PCSTK_OP_STEP, 11'h000));
        chk("pc", 32'h1, 32'(pc_q));
        chk("irq", 32'h1, 32'(irq_q));
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("pc", 32'h0, 32'(pc_q));
        chk("sp", 32'h1f, 32'(stack_ptr_q));
        chk("irq", 32'h0, 32'(irq_q));
        rdchk("stat", `PCSTK_IDX_STAT, 32'h0);
        finish_test();
    end
endmodule : program_counter_and_call_stack_tb

`default_nettype wire
